// >>> coa_operand_addressing.sv
// What this block does
// RULE_01 - An 8-bit index register supplies the index for every indexed addressing mode.
// RULE_02 - An 8-bit stack pointer always points at the current top of stack in data memory.
// RULE_03 - The program counter is 16 bits and its bits 15:8 sit in their own high-byte register.
// RULE_04 - Bits 7:0 of the program counter sit in their own low-byte register.
// RULE_05 - Source immediate takes operand one as the source, writes A, F, SP or X, two bytes.
// RULE_06 - Source direct reads the source at operand one, writes A or X, which is also source two.
// RULE_07 - Source indexed reads at operand one plus X and writes the A or X named by the opcode.
// RULE_08 - Destination direct writes at operand one from A or X, the location being source two.
// RULE_09 - Destination indexed writes at operand one plus X from A, the location is source two.
// RULE_10 - Direct destination with immediate: write at operand one, source operand two, 3 bytes.
// RULE_11 - Core registers change only through execution and are not in the peripheral space.
// RULE_12 - Indexed addresses are the operand plus X modulo 256 with the carry dropped.
// RULE_13 - Reset clears the index, stack pointer and both program counter bytes.
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module coa_operand_addressing import coa_pkg::*; #(
	parameter int W = `COA_BYTE_W
) (
	input wire logic clock, // Core clock, 100 MHz
	input wire logic rst, // Async reset, active high
	input wire logic req_valid, // Decode request pulse
	input wire coa_req_t req, // Opcode fields and operands
	input wire coa_wb_t wb, // Result write-back to X or SP
	input wire logic sp_push, // Stack push step
	input wire logic sp_pop, // Stack pop step
	input wire logic pc_load, // Jump load
	input wire logic [`COA_PC_W-1:0] pc_target, // Jump target
	output logic plan_valid_r, // Plan ready pulse
	output coa_plan_t plan_r, // Decoded operand plan
	output logic [W-1:0] index_value_r, // Index register
	output logic [W-1:0] stack_top_pointer_r, // Stack pointer
	output logic [W-1:0] program_counter_high_r, // PC high byte
	output logic [W-1:0] program_counter_low_r // PC low byte
);
	coa_plan_t plan_nxt;
	logic indexed;
	logic [W-1:0] eff_addr;
	logic is_src;
	logic pc_step;

	// Decide whether operand one is an index offset
	function automatic logic mode_indexed(input coa_mode_t m);
		mode_indexed = (m == COA_SRC_IDX) || (m == COA_DST_IDX);
	endfunction

	// Length in bytes for each mode
	function automatic logic [`COA_LEN_W-1:0] mode_len(input coa_mode_t m);
		case (m)
			COA_SRC_IMM: mode_len = `COA_LEN_TWO; // RULE_05
			COA_SRC_DIR: mode_len = `COA_LEN_TWO; // RULE_06
			COA_SRC_IDX: mode_len = `COA_LEN_TWO; // RULE_07
			COA_DST_DIR: mode_len = `COA_LEN_TWO; // RULE_08
			COA_DST_IDX: mode_len = `COA_LEN_TWO; // RULE_09
			COA_DST_DIR_IMM: mode_len = `COA_LEN_THREE; // RULE_10
			default: mode_len = `COA_LEN_NONE;
		endcase
	endfunction

	// Indexed modes add X, others pass operand one
	assign indexed = mode_indexed(req.mode); // RULE_07 RULE_09
	assign is_src = (req.mode == COA_SRC_IMM) || (req.mode == COA_SRC_DIR) ||
		(req.mode == COA_SRC_IDX);
	assign pc_step = req_valid;

	coa_addr_gen #(.W(W)) i_coa_addr_gen (
		.op1(req.op1),
		.index(index_value_r),
		.indexed(indexed),
		.addr(eff_addr)
	);

	// Build the operand plan for the current request
	always_comb begin
		plan_nxt = '0;
		plan_nxt.addr = eff_addr;
		plan_nxt.reg_space = req.reg_space;
		plan_nxt.len = mode_len(req.mode);
		plan_nxt.src2_loc = COA_LOC_NONE;
		case (req.mode)
			COA_SRC_IMM: begin
				plan_nxt.src_loc = COA_LOC_IMM; // RULE_05
				plan_nxt.imm = req.op1; // RULE_05
				plan_nxt.dst_loc = COA_LOC_REG; // RULE_05
				plan_nxt.dst_reg = req.reg_sel; // RULE_05
				plan_nxt.src2_loc = req.arith ? COA_LOC_REG : COA_LOC_NONE;
				plan_nxt.src_reg = req.reg_sel;
			end
			COA_SRC_DIR, COA_SRC_IDX: begin
				plan_nxt.mem_rd = 1'b1; // RULE_06 RULE_07
				plan_nxt.src_loc = COA_LOC_MEM; // RULE_06 RULE_07
				plan_nxt.dst_loc = COA_LOC_REG;
				plan_nxt.dst_reg = (req.reg_sel == COA_REG_X) ? COA_REG_X : COA_REG_ACC;
				plan_nxt.src_reg = plan_nxt.dst_reg; // RULE_06
				plan_nxt.src2_loc = req.arith ? COA_LOC_REG : COA_LOC_NONE; // RULE_06
			end
			COA_DST_DIR: begin
				plan_nxt.mem_wr = 1'b1; // RULE_08
				plan_nxt.mem_rd = req.arith; // RULE_08
				plan_nxt.src_loc = COA_LOC_REG; // RULE_08
				plan_nxt.src_reg = (req.reg_sel == COA_REG_X) ? COA_REG_X : COA_REG_ACC;
				plan_nxt.dst_loc = COA_LOC_MEM;
				plan_nxt.src2_loc = req.arith ? COA_LOC_MEM : COA_LOC_NONE; // RULE_08
			end
			COA_DST_IDX: begin
				plan_nxt.mem_wr = 1'b1; // RULE_09
				plan_nxt.mem_rd = req.arith; // RULE_09
				plan_nxt.src_loc = COA_LOC_REG; // RULE_09
				plan_nxt.src_reg = COA_REG_ACC; // RULE_09
				plan_nxt.dst_loc = COA_LOC_MEM;
				plan_nxt.src2_loc = req.arith ? COA_LOC_MEM : COA_LOC_NONE; // RULE_09
			end
			COA_DST_DIR_IMM: begin
				plan_nxt.mem_wr = 1'b1; // RULE_10
				plan_nxt.mem_rd = req.arith; // RULE_10
				plan_nxt.src_loc = COA_LOC_IMM; // RULE_10
				plan_nxt.imm = req.op2; // RULE_10
				plan_nxt.dst_loc = COA_LOC_MEM;
				plan_nxt.src2_loc = req.arith ? COA_LOC_MEM : COA_LOC_NONE; // RULE_10
			end
			default: begin
				plan_nxt.src_loc = COA_LOC_NONE;
				plan_nxt.dst_loc = COA_LOC_NONE;
			end
		endcase
	end

	// Plan register, held until the next request
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			plan_valid_r <= 1'b0;
			plan_r <= '0;
		end else begin
			plan_valid_r <= req_valid;
			if (req_valid) begin
				plan_r <= plan_nxt;
			end
		end
	end

	// Core registers; PC advanced by each decoded instruction, X and SP by write-back and stack steps
	coa_core_regs #(.W(W)) i_coa_core_regs (
		.clock(clock),
		.rst(rst),
		.wb(wb),
		.sp_push(sp_push),
		.sp_pop(sp_pop),
		.pc_step(pc_step),
		.pc_len(plan_nxt.len),
		.pc_load(pc_load),
		.pc_target(pc_target),
		.index_value_r(index_value_r),
		.stack_top_pointer_r(stack_top_pointer_r),
		.program_counter_high_r(program_counter_high_r),
		.program_counter_low_r(program_counter_low_r)
	);

	// Helper view of the full program counter
	logic [`COA_PC_W-1:0] pc_view;
	assign pc_view = {program_counter_high_r, program_counter_low_r};

	property p_idx_addr;
		@(posedge clock) disable iff (rst)
		req_valid && mode_indexed(req.mode) |=>
			plan_r.addr == W'($past(req.op1) + $past(index_value_r));
	endproperty
	a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong"); // RULE_12

	property p_dir_addr;
		@(posedge clock) disable iff (rst)
		req_valid && (req.mode == COA_SRC_DIR || req.mode == COA_DST_DIR ||
			req.mode == COA_DST_DIR_IMM) |=> plan_r.addr == $past(req.op1);
	endproperty
	a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong"); // RULE_06

	property p_imm_src;
		@(posedge clock) disable iff (rst)
		req_valid && req.mode == COA_SRC_IMM |=> plan_r.src_loc == COA_LOC_IMM &&
			plan_r.imm == $past(req.op1) && plan_r.dst_reg == $past(req.reg_sel) &&
			plan_r.len == `COA_LEN_TWO && !plan_r.mem_rd && !plan_r.mem_wr;
	endproperty
	a_imm_src: assert property (p_imm_src) else $error("source immediate plan wrong"); // RULE_05

	property p_src_mem;
		@(posedge clock) disable iff (rst)
		req_valid && (req.mode == COA_SRC_DIR || req.mode == COA_SRC_IDX) |=>
			plan_r.mem_rd && !plan_r.mem_wr && plan_r.dst_loc == COA_LOC_REG &&
			plan_r.dst_reg != COA_REG_SP && plan_r.dst_reg != COA_REG_FLAGS;
	endproperty
	a_src_mem: assert property (p_src_mem) else $error("source memory plan wrong"); // RULE_07

	property p_dst_idx;
		@(posedge clock) disable iff (rst)
		req_valid && req.mode == COA_DST_IDX |=> plan_r.mem_wr &&
			plan_r.src_reg == COA_REG_ACC && plan_r.len == `COA_LEN_TWO &&
			(plan_r.src2_loc == COA_LOC_MEM) == $past(req.arith);
	endproperty
	a_dst_idx: assert property (p_dst_idx) else $error("destination indexed plan wrong"); // RULE_09

	property p_dst_dir;
		@(posedge clock) disable iff (rst)
		req_valid && req.mode == COA_DST_DIR |=> plan_r.mem_wr &&
			plan_r.mem_rd == $past(req.arith) && plan_r.src_loc == COA_LOC_REG;
	endproperty
	a_dst_dir: assert property (p_dst_dir) else $error("destination direct plan wrong"); // RULE_08

	property p_three_byte;
		@(posedge clock) disable iff (rst)
		req_valid && req.mode == COA_DST_DIR_IMM && !pc_load |=>
			plan_r.len == `COA_LEN_THREE && plan_r.imm == $past(req.op2) &&
			pc_view == $past(pc_view) + 16'h0003;
	endproperty
	a_three_byte: assert property (p_three_byte) else $error("three byte step wrong"); // RULE_10

	property p_pc_split;
		@(posedge clock) disable iff (rst)
		pc_load |=> program_counter_high_r == $past(pc_target[15:8]) &&
			program_counter_low_r == $past(pc_target[7:0]);
	endproperty
	a_pc_split: assert property (p_pc_split) else $error("pc bytes do not match load"); // RULE_03

	property p_pc_hold;
		@(posedge clock) disable iff (rst)
		!req_valid && !pc_load |=> $stable(pc_view);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved without cause"); // RULE_04

	property p_x_only_wb;
		@(posedge clock) disable iff (rst)
		!(wb.valid && wb.dst == COA_REG_X) |=> $stable(index_value_r);
	endproperty
	a_x_only_wb: assert property (p_x_only_wb) else $error("index changed without write"); // RULE_11

	property p_sp_push;
		@(posedge clock) disable iff (rst)
		sp_push && !sp_pop && !(wb.valid && wb.dst == COA_REG_SP) |=>
			stack_top_pointer_r == W'($past(stack_top_pointer_r) + 8'h01);
	endproperty
	a_sp_push: assert property (p_sp_push) else $error("stack push step wrong"); // RULE_02

	property p_x_write;
		@(posedge clock) disable iff (rst)
		wb.valid && wb.dst == COA_REG_X |=> index_value_r == $past(wb.data);
	endproperty
	a_x_write: assert property (p_x_write) else $error("index write lost"); // RULE_01

	property p_reset_clear;
		@(posedge clock) $fell(rst) |-> index_value_r == 8'h00 &&
			stack_top_pointer_r == 8'h00 && pc_view == 16'h0000;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear"); // RULE_13

	property p_sp_pop;
		@(posedge clock) disable iff (rst)
		sp_pop && !sp_push && !(wb.valid && wb.dst == COA_REG_SP) |=>
			stack_top_pointer_r == W'($past(stack_top_pointer_r) - 8'h01);
	endproperty
	a_sp_pop: assert property (p_sp_pop) else $error("stack pop step wrong"); // RULE_02

	property p_sp_write;
		@(posedge clock) disable iff (rst)
		wb.valid && wb.dst == COA_REG_SP |=> stack_top_pointer_r == $past(wb.data);
	endproperty
	a_sp_write: assert property (p_sp_write) else $error("stack write lost"); // RULE_02

	property p_src_reg_dst;
		@(posedge clock) disable iff (rst)
		req_valid && is_src |=> !plan_r.mem_wr && plan_r.dst_loc == COA_LOC_REG &&
			plan_r.len == `COA_LEN_TWO;
	endproperty
	a_src_reg_dst: assert property (p_src_reg_dst) else $error("source mode plan wrong"); // RULE_06

	property p_pc_two;
		@(posedge clock) disable iff (rst)
		req_valid && !pc_load && (is_src || req.mode == COA_DST_DIR ||
			req.mode == COA_DST_IDX) |=> pc_view == $past(pc_view) + 16'h0002;
	endproperty
	a_pc_two: assert property (p_pc_two) else $error("two byte step wrong"); // RULE_04

	property p_src_second;
		@(posedge clock) disable iff (rst)
		req_valid && is_src && req.arith |=> plan_r.src2_loc == COA_LOC_REG &&
			plan_r.src_reg == plan_r.dst_reg;
	endproperty
	a_src_second: assert property (p_src_second) else $error("source second wrong"); // RULE_06

	property p_dst_second;
		@(posedge clock) disable iff (rst)
		req_valid && (req.mode == COA_DST_DIR || req.mode == COA_DST_IDX ||
			req.mode == COA_DST_DIR_IMM) |=> plan_r.dst_loc == COA_LOC_MEM &&
			(plan_r.src2_loc == COA_LOC_MEM) == $past(req.arith) &&
			plan_r.reg_space == $past(req.reg_space);
	endproperty
	a_dst_second: assert property (p_dst_second) else $error("destination second wrong"); // RULE_10

	property p_plan_hold;
		@(posedge clock) disable iff (rst)
		!req_valid |=> !plan_valid_r && $stable(plan_r);
	endproperty
	a_plan_hold: assert property (p_plan_hold) else $error("plan moved without request"); // RULE_11
endmodule
`default_nettype wire

// >>> coa_consts.svh
`ifndef COA_CONSTS_SVH
`define COA_CONSTS_SVH
// Data and address widths of the core
`define COA_BYTE_W 8
`define COA_PC_W 16
`define COA_LEN_W 2
// Reset values of the core registers
`define COA_X_RST 8'h00
`define COA_SP_RST 8'h00
`define COA_PCH_RST 8'h00
`define COA_PCL_RST 8'h00
// Instruction lengths in bytes
`define COA_LEN_NONE 2'h0
`define COA_LEN_TWO 2'h2
`define COA_LEN_THREE 2'h3
// Program counter byte fields
`define COA_PCH_MSB 15
`define COA_PCH_LSB 8
`define COA_PCL_MSB 7
`define COA_PCL_LSB 0
// Stack pointer step
`define COA_SP_STEP 8'h01
`endif

// >>> coa_pkg.sv
package coa_pkg;
	// Addressing modes handled by this block
	typedef enum logic [2:0] {
		COA_SRC_IMM,
		COA_SRC_DIR,
		COA_SRC_IDX,
		COA_DST_DIR,
		COA_DST_IDX,
		COA_DST_DIR_IMM
	} coa_mode_t;
	// Register named by the opcode
	typedef enum logic [1:0] {
		COA_REG_ACC,
		COA_REG_FLAGS,
		COA_REG_SP,
		COA_REG_X
	} coa_reg_t;
	// Where an operand or result lives
	typedef enum logic [1:0] {
		COA_LOC_REG,
		COA_LOC_IMM,
		COA_LOC_MEM,
		COA_LOC_NONE
	} coa_loc_t;
	// Decode request from the opcode stage
	typedef struct packed {
		coa_mode_t mode;
		coa_reg_t reg_sel;
		logic reg_space;
		logic arith;
		logic [7:0] op1;
		logic [7:0] op2;
	} coa_req_t;
	// Decoded operand plan for the execute stage
	typedef struct packed {
		logic [7:0] addr;
		logic reg_space;
		logic mem_rd;
		logic mem_wr;
		coa_loc_t src_loc;
		coa_reg_t src_reg;
		coa_loc_t src2_loc;
		coa_loc_t dst_loc;
		coa_reg_t dst_reg;
		logic [7:0] imm;
		logic [1:0] len;
	} coa_plan_t;
	// Result write-back into a core register
	typedef struct packed {
		logic valid;
		coa_reg_t dst;
		logic [7:0] data;
	} coa_wb_t;
endpackage

// >>> coa_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module coa_addr_gen import coa_pkg::*; #(
	parameter int W = `COA_BYTE_W
) (
	input wire logic [W-1:0] op1, // Operand byte
	input wire logic [W-1:0] index, // Index register value
	input wire logic indexed, // Add the index
	output logic [W-1:0] addr // Operand address
);
	logic [W:0] sum_full;
	// Sum wraps at the byte width, carry dropped
	assign sum_full = {1'b0, op1} + {1'b0, index}; // RULE_12
	assign addr = indexed ? sum_full[W-1:0] : op1; // RULE_12
endmodule
`default_nettype wire

// >>> coa_core_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module coa_core_regs import coa_pkg::*; #(
	parameter int W = `COA_BYTE_W
) (
	input wire logic clock, // Core clock
	input wire logic rst, // Async reset, active high
	input wire coa_wb_t wb, // Result write-back
	input wire logic sp_push, // Stack grows by one
	input wire logic sp_pop, // Stack shrinks by one
	input wire logic pc_step, // Advance past an instruction
	input wire logic [`COA_LEN_W-1:0] pc_len, // Length to advance
	input wire logic pc_load, // Jump load
	input wire logic [`COA_PC_W-1:0] pc_target, // Jump target
	output logic [W-1:0] index_value_r, // Index register
	output logic [W-1:0] stack_top_pointer_r, // Stack pointer
	output logic [W-1:0] program_counter_high_r, // PC bits 15:8
	output logic [W-1:0] program_counter_low_r // PC bits 7:0
);
	logic [W-1:0] index_value_nxt;
	logic [W-1:0] stack_top_pointer_nxt;
	logic [`COA_PC_W-1:0] pc_cur;
	logic [`COA_PC_W-1:0] pc_nxt;
	logic wb_x;
	logic wb_sp;
	// Only executed instructions reach these registers
	assign wb_x = wb.valid && (wb.dst == COA_REG_X); // RULE_11
	assign wb_sp = wb.valid && (wb.dst == COA_REG_SP); // RULE_11
	assign index_value_nxt = wb_x ? wb.data : index_value_r; // RULE_01
	// Write-back wins over a stack step in the same cycle
	assign stack_top_pointer_nxt = wb_sp ? wb.data :
		sp_push ? stack_top_pointer_r + `COA_SP_STEP :
		sp_pop ? stack_top_pointer_r - `COA_SP_STEP : stack_top_pointer_r; // RULE_02
	assign pc_cur = {program_counter_high_r, program_counter_low_r};
	// Jump beats sequential advance
	assign pc_nxt = pc_load ? pc_target :
		pc_step ? pc_cur + {{(`COA_PC_W-`COA_LEN_W){1'b0}}, pc_len} : pc_cur;
	// Core register flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			index_value_r <= `COA_X_RST; // RULE_13
			stack_top_pointer_r <= `COA_SP_RST; // RULE_13
			program_counter_high_r <= `COA_PCH_RST; // RULE_13
			program_counter_low_r <= `COA_PCL_RST; // RULE_13
		end else begin
			index_value_r <= index_value_nxt; // RULE_01
			stack_top_pointer_r <= stack_top_pointer_nxt; // RULE_02
			program_counter_high_r <= pc_nxt[`COA_PCH_MSB:`COA_PCH_LSB]; // RULE_03
			program_counter_low_r <= pc_nxt[`COA_PCL_MSB:`COA_PCL_LSB]; // RULE_04
		end
	end
endmodule
`default_nettype wire

// >>> coa_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module coa_mem_model import coa_pkg::*; (
	input wire logic clock, // Core clock
	input wire logic plan_valid, // Plan pulse from the block
	input wire coa_plan_t plan, // Operand plan
	input wire logic [7:0] wr_data, // Result byte from execute
	output logic [7:0] rd_data // Source byte back to execute
);
	logic [7:0] ram_mem [256];
	logic [7:0] reg_mem [256];
	logic [7:0] rd_q = 8'h00;
	// Read data comes from one register only
	assign rd_data = rd_q;
	// Address-keyed contents so a wrong address or space shows up in the data
	initial begin
		for (int i = 0; i < 256; i++) begin
			ram_mem[i] = i[7:0];
			reg_mem[i] = ~i[7:0];
		end
	end
	// Serve reads and writes; between reads the read data register inverts itself every cycle
	always @(posedge clock) begin
		if (plan_valid && plan.mem_rd)
			rd_q <= plan.reg_space ? reg_mem[plan.addr] : ram_mem[plan.addr];
		else
			rd_q <= ~rd_q;
		if (plan_valid && plan.mem_wr && plan.reg_space)
			reg_mem[plan.addr] <= wr_data;
		else if (plan_valid && plan.mem_wr)
			ram_mem[plan.addr] <= wr_data;
	end
endmodule
`default_nettype wire

// >>> coa_operand_addressing_test.sv
`timescale 1ns/100ps
`default_nettype none
module coa_operand_addressing_test import coa_pkg::*; ;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	coa_req_t req = '0;
	coa_wb_t wb = '0;
	logic sp_push = 1'b0;
	logic sp_pop = 1'b0;
	logic pc_load = 1'b0;
	logic [15:0] pc_target = 16'h0000;
	logic [7:0] wr_data = 8'hC3;
	logic plan_valid_r;
	coa_plan_t plan_r;
	logic [7:0] x_r, sp_r, pch_r, pcl_r, rd_data;
	int n_errors = 0;
	int checks = 0;
	logic [15:0] exp_pc;
	logic [7:0] exp_x;
	logic pend = 1'b0;
	logic [7:0] pend_val;
	bit wr_seen [512];

	// 100 MHz core clock
	always #5 clock = ~clock;

	coa_operand_addressing i_coa_operand_addressing (
		.clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .wb(wb),
		.sp_push(sp_push), .sp_pop(sp_pop), .pc_load(pc_load), .pc_target(pc_target),
		.plan_valid_r(plan_valid_r), .plan_r(plan_r), .index_value_r(x_r),
		.stack_top_pointer_r(sp_r), .program_counter_high_r(pch_r),
		.program_counter_low_r(pcl_r)
	);
	coa_mem_model i_coa_mem_model (
		.clock(clock), .plan_valid(plan_valid_r), .plan(plan_r), .wr_data(wr_data),
		.rd_data(rd_data)
	);

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One cycle of core-register controls; each call overwrites the previous one
	task automatic step(input logic v, input coa_reg_t d, input logic [7:0] dat,
		input logic pu, input logic po, input logic ld, input logic [15:0] tg);
		wb = '{valid: v, dst: d, data: dat};
		sp_push = pu;
		sp_pop = po;
		pc_load = ld;
		pc_target = tg;
		@(negedge clock);
	endtask

	// Issue one decode request and check the plan one cycle later; leaves req_valid up
	task automatic decode(input coa_mode_t m, input coa_reg_t rs, input logic sp,
		input logic ar, input logic [7:0] o1, input logic [7:0] o2);
		logic src;
		logic [7:0] ea;
		logic [1:0] len;
		src = (m == COA_SRC_IMM) || (m == COA_SRC_DIR) || (m == COA_SRC_IDX);
		ea = (m == COA_SRC_IDX || m == COA_DST_IDX) ? 8'(o1 + exp_x) : o1;
		len = (m == COA_DST_DIR_IMM) ? 2'h3 : 2'h2;
		req_valid = 1'b1;
		req = '{mode: m, reg_sel: rs, reg_space: sp, arith: ar, op1: o1, op2: o2};
		@(negedge clock);
		if (pend)
			check(rd_data, pend_val);
		exp_pc = exp_pc + 16'(len);
		check(plan_valid_r, 1'b1);
		check(plan_r.len, len);
		check({pch_r, pcl_r}, exp_pc);
		check(plan_r.mem_wr, !src);
		check(plan_r.dst_loc, src ? COA_LOC_REG : COA_LOC_MEM);
		if (m == COA_SRC_IMM) begin
			check(plan_r.src_loc, COA_LOC_IMM);
			check(plan_r.imm, o1);
			check(plan_r.dst_reg, rs);
			check(plan_r.mem_rd, 1'b0);
		end else begin
			check(plan_r.addr, ea);
			check(plan_r.reg_space, sp);
		end
		if (m == COA_SRC_DIR || m == COA_SRC_IDX) begin
			check(plan_r.src_loc, COA_LOC_MEM);
			check(plan_r.mem_rd, 1'b1);
			check(plan_r.dst_reg, rs == COA_REG_X ? COA_REG_X : COA_REG_ACC);
			check(plan_r.src_reg, rs == COA_REG_X ? COA_REG_X : COA_REG_ACC);
		end else if (!src) begin
			check(plan_r.mem_rd, ar);
			check(plan_r.src_loc, m == COA_DST_DIR_IMM ? COA_LOC_IMM : COA_LOC_REG);
			if (m == COA_DST_DIR_IMM)
				check(plan_r.imm, o2);
			else
				check(plan_r.src_reg, (m == COA_DST_DIR && rs == COA_REG_X) ? 2'h3 : 2'h0);
		end
		if (ar)
			check(plan_r.src2_loc, src ? COA_LOC_REG : COA_LOC_MEM);
		else
			check(plan_r.src2_loc, COA_LOC_NONE);
		pend = (m == COA_SRC_DIR) || (m == COA_SRC_IDX) || (!src && ar);
		// A location written by an earlier destination mode reads back the result byte
		pend_val = wr_seen[{sp, ea}] ? wr_data : (sp ? ~ea : ea);
		if (!src)
			wr_seen[{sp, ea}] = 1'b1;
	endtask

	// Cut a hang short
	initial begin
		#20000;
		n_errors++;
		print_verdict();
	end

	initial begin
		repeat (16) @(negedge clock);
		check({x_r, sp_r}, 16'h0000);
		check({pch_r, pcl_r}, 16'h0000);
		rst = 1'b0;
		step(1'b1, COA_REG_X, 8'hF0, 1'b0, 1'b0, 1'b1, 16'h12FE);
		check(x_r, 8'hF0);
		check({pch_r, pcl_r}, 16'h12FE);
		step(1'b1, COA_REG_SP, 8'h7F, 1'b0, 1'b0, 1'b0, 16'h0000);
		check(sp_r, 8'h7F);
		step(1'b0, COA_REG_ACC, 8'h00, 1'b1, 1'b0, 1'b0, 16'h0000);
		check(sp_r, 8'h80);
		step(1'b0, COA_REG_ACC, 8'h00, 1'b0, 1'b1, 1'b0, 16'h0000);
		check(sp_r, 8'h7F);
		step(1'b1, COA_REG_ACC, 8'h33, 1'b1, 1'b1, 1'b0, 16'h0000);
		check({x_r, sp_r}, 16'hF080);
		step(1'b1, COA_REG_SP, 8'h10, 1'b1, 1'b0, 1'b0, 16'h0000);
		check(sp_r, 8'h10);
		step(1'b0, COA_REG_ACC, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0000);
		check({pch_r, pcl_r, sp_r}, 24'h12FE10);
		exp_x = 8'hF0;
		exp_pc = 16'h12FE;
		// Every mode, register choice and arith setting, back to back
		for (int a = 0; a < 2; a++)
			for (int r = 0; r < 4; r++)
				for (int m = 0; m < 6; m++)
					decode(coa_mode_t'(m), coa_reg_t'(r), m[0], a[0], 8'(8'h20 + m * 16 + r),
						8'h5A ^ 8'(r));
		req_valid = 1'b0;
		@(negedge clock);
		if (pend)
			check(rd_data, pend_val);
		pend = 1'b0;
		check(plan_valid_r, 1'b0);
		check(plan_r.len, 2'h3);
		check({x_r, sp_r}, 16'hF010);
		// Reset in mid-run, then one indexed decode from zero
		rst = 1'b1;
		@(negedge clock);
		check({x_r, sp_r, plan_valid_r}, 16'h0000);
		check({pch_r, pcl_r}, 16'h0000);
		rst = 1'b0;
		exp_x = 8'h00;
		exp_pc = 16'h0000;
		decode(COA_SRC_IDX, COA_REG_X, 1'b0, 1'b0, 8'h05, 8'h00);
		req_valid = 1'b0;
		@(negedge clock);
		check(rd_data, pend_val);
		// A mode outside the six decoded ones leaves the length at zero
		req_valid = 1'b1;
		req.mode = coa_mode_t'(3'h6);
		@(negedge clock);
		check(plan_r.len, 2'h0);
		check({pch_r, pcl_r}, 16'h0002);
		req_valid = 1'b0;
		@(negedge clock);
		print_verdict();
	end
endmodule
`default_nettype wire
